// ### reset_pin_and_clock_output_params.svh
/*
  Constants for the reset pin and clock output block.
  Assumes inclusion by bare name from the design, the checker and the bench.
*/
`ifndef RESET_PIN_AND_CLOCK_OUTPUT_PARAMS_SVH
`define RESET_PIN_AND_CLOCK_OUTPUT_PARAMS_SVH
`define RST_VECTOR_ADDR 22'h3F_FFC0
`define WD_RESET_CYCLES 10'h200
`define CLOCK_OUT_DISABLE_BIT 3
`define RATIO_DIV1 2'h0
`define RATIO_DIV2 2'h1
`define RATIO_DIV4 2'h2
`define RATIO_RESET 2'h2
`endif

// ### reset_pin_and_clock_output_pkg.sv
/*
  Types for the reset pin and clock output block.
  Assumes the constants header is on the include path.
*/
package reset_pin_and_clock_output_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_WD_DRIVE, ST_PIN_HELD} rst_state_t;
  typedef struct packed {
    logic [1:0] ratio;
    logic clock_out_disable;
  } clk_cfg_t;
endpackage

// ### reset_pin_and_clock_output.sv
/*
  Reset pin open-drain control, reset vector load, clock output divider, test mode select.
  Assumes mclk is the system clock, which also stands for the input clock.
*/
`timescale 1ns/10ps
`include "reset_pin_and_clock_output_params.svh"
`default_nettype none
module reset_pin_and_clock_output (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire reset_pin_and_clock_output_pkg::clk_cfg_t cfg_in,
  input wire logic cfg_write,
  input wire logic watchdog_reset,
  input wire logic device_reset_pin_n_in,
  output logic device_reset_pin_n_out,
  output logic device_reset_pin_n_oe,
  input wire logic test_reset,
  output logic ext_clock_out,
  output logic ext_clock_out_oe,
  output logic core_halt,
  output logic core_start,
  output logic [21:0] pc_load,
  output logic scan_mode
);
  logic [2:0] pin_sync_ff;
  logic pin_low_ff;
  logic [2:0] trst_sync_ff;
  logic scan_ff;
  reset_pin_and_clock_output_pkg::rst_state_t state_ff;
  reset_pin_and_clock_output_pkg::clk_cfg_t cfg_ff;
  logic [9:0] wd_cnt_ff;
  logic [1:0] div_cnt_ff;
  logic [1:0] act_ratio_ff;
  logic clk_ff;
  logic start_ff;
  logic [21:0] pc_ff;
  logic [1:0] nxt_div_cnt;

  // Pin synchroniser, filtered on agreement of stages two and three
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_sync_ff <= 3'h7;
      pin_low_ff <= 1'b0;
    end else if (clk_en) begin
      pin_sync_ff <= {pin_sync_ff[1:0], device_reset_pin_n_in};
      if (pin_sync_ff[2] == pin_sync_ff[1]) begin
        pin_low_ff <= ~pin_sync_ff[2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trst_sync_ff <= 3'h0;
      scan_ff <= 1'b0;
    end else if (clk_en) begin
      trst_sync_ff <= {trst_sync_ff[1:0], test_reset};
      if (trst_sync_ff[2] == trst_sync_ff[1]) begin
        scan_ff <= trst_sync_ff[2];
      end
    end
  end

  // Reset sequencing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= reset_pin_and_clock_output_pkg::ST_RUN;
      wd_cnt_ff <= 10'h000;
      start_ff <= 1'b0;
      pc_ff <= 22'h00_0000;
    end else if (clk_en) begin
      start_ff <= 1'b0;
      case (state_ff)
        reset_pin_and_clock_output_pkg::ST_RUN: begin
          if (watchdog_reset) begin
            state_ff <= reset_pin_and_clock_output_pkg::ST_WD_DRIVE;
            wd_cnt_ff <= `WD_RESET_CYCLES - 10'h001;
            pc_ff <= `RST_VECTOR_ADDR;
          end else if (pin_low_ff) begin
            state_ff <= reset_pin_and_clock_output_pkg::ST_PIN_HELD;
            pc_ff <= `RST_VECTOR_ADDR;
          end
        end
        reset_pin_and_clock_output_pkg::ST_WD_DRIVE: begin
          if (wd_cnt_ff == 10'h000) begin
            state_ff <= reset_pin_and_clock_output_pkg::ST_PIN_HELD;
          end else begin
            wd_cnt_ff <= wd_cnt_ff - 10'h001;
          end
        end
        reset_pin_and_clock_output_pkg::ST_PIN_HELD: begin
          if (!pin_low_ff) begin
            state_ff <= reset_pin_and_clock_output_pkg::ST_RUN;
            start_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= reset_pin_and_clock_output_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Configuration store
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_ff.ratio <= `RATIO_RESET;
      cfg_ff.clock_out_disable <= 1'b0;
    end else if (clk_en && cfg_write) begin
      cfg_ff <= cfg_in;
    end
  end

  // Divider: ratio changes at the end of a full output period, or on every cycle in divide-by-one
  always_comb begin
    nxt_div_cnt = div_cnt_ff + 2'h1;
    if (act_ratio_ff == `RATIO_DIV1) begin
      nxt_div_cnt = 2'h0;
    end else if (act_ratio_ff == `RATIO_DIV2 && div_cnt_ff == 2'h1) begin
      nxt_div_cnt = 2'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt_ff <= 2'h0;
      act_ratio_ff <= `RATIO_RESET;
      clk_ff <= 1'b0;
    end else if (clk_en) begin
      div_cnt_ff <= nxt_div_cnt;
      if (nxt_div_cnt == 2'h0) begin
        act_ratio_ff <= (cfg_ff.ratio == 2'h3) ? `RATIO_DIV4 : cfg_ff.ratio;
      end
      case (act_ratio_ff)
        `RATIO_DIV1: clk_ff <= ~clk_ff;
        `RATIO_DIV2: clk_ff <= (nxt_div_cnt == 2'h1);
        default: clk_ff <= nxt_div_cnt[1];
      endcase
    end
  end

  // Disable holds the pin low but still driven
  assign ext_clock_out = cfg_ff.clock_out_disable ? 1'b0 : clk_ff;
  assign ext_clock_out_oe = 1'b1;
  assign device_reset_pin_n_out = 1'b0;
  assign device_reset_pin_n_oe = (state_ff == reset_pin_and_clock_output_pkg::ST_WD_DRIVE);
  assign core_halt = (state_ff != reset_pin_and_clock_output_pkg::ST_RUN);
  assign core_start = start_ff;
  assign pc_load = pc_ff;
  assign scan_mode = scan_ff;
endmodule
`default_nettype wire

// ### reset_pin_and_clock_output_monitor.sv
/* Checker for the reset pin and clock output block.
   Assumes binding onto the block's top module. */
`timescale 1ns/10ps
`include "reset_pin_and_clock_output_params.svh"
`default_nettype none
module reset_pin_and_clock_output_monitor (
  input wire logic mclk, rst_n, clk_en, cfg_write, watchdog_reset, device_reset_pin_n_in,
  input wire reset_pin_and_clock_output_pkg::clk_cfg_t cfg_in,
  input wire logic device_reset_pin_n_out, device_reset_pin_n_oe, ext_clock_out,
  input wire logic ext_clock_out_oe, core_halt, core_start,
  input wire logic [21:0] pc_load
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [9:0] cnt_ff;
  always_ff @(posedge mclk)
    if (!rst_n || !device_reset_pin_n_oe) cnt_ff <= 10'h000;
    else cnt_ff <= cnt_ff + 10'h001;
  a_oe_on: assert property (ext_clock_out_oe) else $error("clock oe low");
  a_pin_low: assert property (!device_reset_pin_n_out) else $error("pin high");
  a_wd_drive: assert property (clk_en && watchdog_reset && !core_halt && !device_reset_pin_n_oe
    |=> device_reset_pin_n_oe) else $error("no pull");
  a_wd_len: assert property ($fell(device_reset_pin_n_oe) |-> cnt_ff == 10'h200)
    else $error("pull length");
  a_vec_load: assert property ($rose(core_halt) |=> pc_load == `RST_VECTOR_ADDR)
    else $error("vector");
  a_start_once: assert property (core_start |=> !core_start) else $error("start");
  a_clk_off: assert property (clk_en && cfg_write && cfg_in.clock_out_disable |=> !ext_clock_out)
    else $error("clock on");
  a_pin_halt: assert property ((!device_reset_pin_n_in && clk_en) [*7] |-> core_halt)
    else $error("no halt");
  a_freeze_clock: assert property (!clk_en |=> $stable(ext_clock_out))
    else $error("clock moved while frozen");
endmodule
bind reset_pin_and_clock_output reset_pin_and_clock_output_monitor i_mon (.mclk, .rst_n, .clk_en,
  .cfg_write, .watchdog_reset, .device_reset_pin_n_in, .cfg_in, .device_reset_pin_n_out,
  .device_reset_pin_n_oe, .ext_clock_out, .ext_clock_out_oe, .core_halt, .core_start,
  .pc_load);
`default_nettype wire

// ### reset_partner.sv
/* External reset source on the reset pin.
   Assumes a pull-up holds the pin high when released. */
`timescale 1ns/10ps
`default_nettype none
module reset_partner (
  input wire logic dev_pull, ext_pull,
  output logic pin_n
);
  assign pin_n = !(dev_pull || ext_pull);
endmodule
`default_nettype wire

// ### testbench.sv
/* Bench for the reset pin and clock output block.
   Assumes design, partner and checker compiled first. */
`timescale 1ns/10ps
`include "reset_pin_and_clock_output_params.svh"
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic mclk = 0, rst_n = 0, wdr = 0, cw = 0, tr = 0, ext = 0;
  reset_pin_and_clock_output_pkg::clk_cfg_t cfg = '0;
  logic pin, po, poe, ck, coe, halt, start, sm, hold;
  logic ce = 1;
  logic [21:0] pc;
  int error_cnt = 0, total_checks = 0, n, r;
  always #5 mclk = ~mclk;
  reset_pin_and_clock_output i_reset_pin_and_clock_output (.mclk(mclk), .rst_n(rst_n),
    .clk_en(ce), .cfg_in(cfg), .cfg_write(cw), .watchdog_reset(wdr),
    .device_reset_pin_n_in(pin), .device_reset_pin_n_out(po), .device_reset_pin_n_oe(poe),
    .test_reset(tr), .ext_clock_out(ck), .ext_clock_out_oe(coe), .core_halt(halt),
    .core_start(start), .pc_load(pc), .scan_mode(sm));
  reset_partner i_reset_partner (.dev_pull(poe), .ext_pull(ext), .pin_n(pin));
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic rises(int e);
    int c;
    logic q;
    c = 0;
    q = ck;
    repeat (16) begin
      tick(1);
      c += (ck === 1'b1 && q === 1'b0);
      q = ck;
    end
    `CHK("clock rises", e, c)
  endtask
  function automatic int exp_rises(int ratio);
    int per[$];
    per = {2, 2, 4, 4};
    return 16 / per[ratio];
  endfunction
  task automatic wait_start;
    for (int i = 0; start !== 1'b1 && i < 20; i++) tick(1);
    `CHK("start", 1'b1, start)
  endtask
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(32'hb027_8df6));
    tick(8);
    rst_n = 1;
    tick(6);
    rises(4);
    ce = 0;
    hold = ck;
    tick(5);
    `CHK("frozen clock", hold, ck)
    ce = 1;
    for (n = 0; n < 6; n++) begin
      r = $urandom % 4;
      cfg.ratio = r[1:0];
      cw = 1;
      tick(1);
      cw = 0;
      tick(8);
      rises(exp_rises(r));
    end
    cfg.clock_out_disable = 1;
    cw = 1;
    tick(1);
    cw = 0;
    tick(1);
    rises(0);
    wdr = 1;
    tick(1);
    wdr = 0;
    `CHK("vector", `RST_VECTOR_ADDR, pc)
    for (n = 0; poe === 1'b1 && n < 600; n++) tick(1);
    `CHK("pull cycles", 512, n)
    wait_start();
    ext = 1;
    tick(7 + $urandom % 10);
    `CHK("halt", 1'b1, halt)
    ext = 0;
    wait_start();
    tr = 1;
    tick(6);
    `CHK("scan on", 1'b1, sm)
    tr = 0;
    tick(6);
    `CHK("scan off", 1'b0, sm)
    rst_n = 0;
    tick(2);
    `CHK("clock oe", 1'b1, coe)
    `CHK("pin out", 1'b0, po)
    rst_n = 1;
    tick(6);
    rises(4);
    summarize();
  end
endmodule
`default_nettype wire
